// [src/ident_pkg.sv]
// constants for the identification register and the control register attribute bit
package ident_pkg;
    localparam int          WORD_W          = 32;
    localparam logic [3:0]  REG_IDENT       = 4'h0;
    localparam logic [3:0]  REG_CONTROL     = 4'h1;
    localparam int          IMPL_LSB        = 24;
    localparam int          ARCH_LSB        = 16;
    localparam int          GEN_LSB         = 13;
    localparam int          CREV_LSB        = 10;
    localparam int          PROD_LSB        = 4;
    localparam int          STEP_LSB        = 0;
    localparam logic [7:0]  ARCH_V5TE       = 8'h05;
    localparam int          ATTR_BIT        = 1;
    localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;
    // arbitrary neutral identity values
    localparam logic [7:0]  IMPL_DEFAULT    = 8'h5A;
    localparam logic [2:0]  GEN_DEFAULT     = 3'h1;
    localparam logic [2:0]  CREV_DEFAULT    = 3'h0;
    localparam logic [5:0]  PROD_DEFAULT    = 6'h11;
    localparam logic [3:0]  STEP_DEFAULT    = 4'h0;
endpackage

// [src/ident_word.sv]
// assembles the constant identification word from its fields
module ident_word
    import ident_pkg::*;
#(
    parameter logic [7:0] IMPL = IMPL_DEFAULT,
    parameter logic [2:0] GEN  = GEN_DEFAULT,
    parameter logic [2:0] CREV = CREV_DEFAULT,
    parameter logic [5:0] PROD = PROD_DEFAULT,
    parameter logic [3:0] STEP = STEP_DEFAULT
) (
    output wire logic [31:0] word
);
    assign word = {IMPL,
                   ARCH_V5TE,
                   GEN,
                   CREV,
                   PROD,
                   STEP};
endmodule

// [src/processor_id_register.sv]
// coprocessor register reads of the identification word and control attribute bit
// Behaviour
// - identification register is 32 bits, constant, writes ignored
// - one word carries maker, product and stepping fields
// - bits 23:16 read 0x05, architecture version 5TE
// - core generation field is fixed per core feature set
// - bits 3:0 hold stepping, zero for first, counting up
// - core revision field independent of stepping field
module processor_id_register
    import ident_pkg::*;
#(
    parameter logic [7:0] IMPL = IMPL_DEFAULT,
    parameter logic [2:0] GEN  = GEN_DEFAULT,
    parameter logic [2:0] CREV = CREV_DEFAULT,
    parameter logic [5:0] PROD = PROD_DEFAULT,
    parameter logic [3:0] STEP = STEP_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [3:0]  reg_num,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] rd_data,
    output logic             rd_valid,
    output logic             attr_enable
);
    ////////////////////////////////////////////////////////////////
    logic [31:0] ident;
    logic [31:0] control;
    logic [31:0] next_control;
    logic [31:0] next_rd_data;
    logic        next_rd_valid;

    ////////////////////////////////////////////////////////////////
    // register number decoding, shared by the write path and the checks; the read path decodes with its own case
    function automatic logic is_ident(input logic [3:0] num);
        return num == REG_IDENT;
    endfunction

    function automatic logic is_control(input logic [3:0] num);
        return num == REG_CONTROL;
    endfunction

    ////////////////////////////////////////////////////////////////
    // identification word, fixed by parameters
    ident_word #(
        .IMPL (IMPL),
        .GEN  (GEN),
        .CREV (CREV),
        .PROD (PROD),
        .STEP (STEP)
    ) u_word (
        .word (ident)
    );

    ////////////////////////////////////////////////////////////////
    // control store: the attribute select is dropped on every write
    always_comb begin
        next_control = control;
        if (wr_en && is_control(reg_num)) begin
            next_control = wr_data;
        end
        next_control[ATTR_BIT] = 1'b0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control <= CONTROL_RESET;
        end else begin
            control <= next_control;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path: one registered answer per request, unmapped numbers read zero
    always_comb begin
        next_rd_valid = rd_en;
        next_rd_data  = 32'h0000_0000;
        if (rd_en) begin
            case (reg_num)
                REG_IDENT:   next_rd_data = ident;
                REG_CONTROL: next_rd_data = control;
                default:     next_rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data  <= 32'h0000_0000;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // attribute is not implemented, so its select never reaches logic
    assign attr_enable = control[ATTR_BIT];

    ////////////////////////////////////////////////////////////////
    chk_ident_arch: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && reg_num == REG_IDENT |=> rd_data[23:16] == ARCH_V5TE)
        else $error("architecture field wrong");
    chk_ident_const: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && reg_num == REG_IDENT ##1 rd_en && reg_num == REG_IDENT |=> rd_data == $past(rd_data))
        else $error("identification word changed");
    chk_ident_step: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && reg_num == REG_IDENT |=> rd_data[3:0] == STEP)
        else $error("stepping field wrong");
    chk_ident_gen: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && reg_num == REG_IDENT |=> rd_data[15:13] == GEN)
        else $error("generation field wrong");
    chk_ident_crev: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && reg_num == REG_IDENT |=> rd_data[12:10] == CREV)
        else $error("core revision field wrong");
    chk_ident_maker: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && reg_num == REG_IDENT |=> rd_data[31:24] == IMPL && rd_data[9:4] == PROD)
        else $error("maker or product field wrong");
    chk_attr_zero: assert property (@(posedge clk) disable iff (!rstn)
        wr_en && reg_num == REG_CONTROL ##1 rd_en && reg_num == REG_CONTROL |=> !rd_data[ATTR_BIT])
        else $error("attribute bit read nonzero");
    chk_ctrl_store: assert property (@(posedge clk) disable iff (!rstn)
        wr_en && reg_num == REG_CONTROL ##1 !wr_en && rd_en && reg_num == REG_CONTROL
        |=> rd_data[31:2] == $past(wr_data[31:2], 2))
        else $error("control write lost");
    chk_rd_valid: assert property (@(posedge clk) disable iff (!rstn)
        rd_en |=> rd_valid)
        else $error("read not answered");

    ////////////////////////////////////////////////////////////////
    // further checks on the read path
    chk_rd_idle: assert property (@(posedge clk) disable iff (!rstn)
        !rd_en |=> !rd_valid && rd_data == 32'h0000_0000)
        else $error("idle read outputs not cleared");

    chk_rd_cause: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid |-> $past(rd_en))
        else $error("read answer without a request");

    chk_rd_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
        rd_valid && !rd_en |=> !rd_valid)
        else $error("read answer stood too long");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && !is_ident(reg_num) && !is_control(reg_num)
        |=> rd_data == 32'h0000_0000)
        else $error("unmapped register read nonzero");

    chk_ctrl_read: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && is_control(reg_num) |=> rd_data == $past(control))
        else $error("control read wrong");

    // a read and a write in the same cycle return the value from before the write
    chk_read_old_ctrl: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && wr_en && is_control(reg_num)
        |=> rd_data == $past(control))
        else $error("same cycle read saw the new control value");

    // looked at one edge later, so the very first reset edge need not settle values
    chk_reset_state: assert property (@(posedge clk)
        !rstn |=> !rd_valid && rd_data == 32'h0000_0000 && control == CONTROL_RESET)
        else $error("reset state wrong");

    ////////////////////////////////////////////////////////////////
    // checks on the identification word as assembled and as read
    chk_word_maker: assert property (@(posedge clk) disable iff (!rstn)
        ident[IMPL_LSB +: 8] == IMPL && ident[PROD_LSB +: 6] == PROD)
        else $error("assembled maker or product field wrong");

    chk_word_arch: assert property (@(posedge clk) disable iff (!rstn)
        ident[ARCH_LSB +: 8] == ARCH_V5TE)
        else $error("assembled architecture field wrong");

    chk_word_step: assert property (@(posedge clk) disable iff (!rstn)
        ident[STEP_LSB +: 4] == STEP)
        else $error("assembled stepping field wrong");

    chk_word_gen: assert property (@(posedge clk) disable iff (!rstn)
        ident[GEN_LSB +: 3] == GEN && ident[CREV_LSB +: 3] == CREV)
        else $error("assembled generation or revision field wrong");

    chk_ident_read_word: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && is_ident(reg_num) |=> rd_data == $past(ident))
        else $error("identification read wrong");

    chk_ident_nowrite: assert property (@(posedge clk) disable iff (!rstn)
        wr_en && is_ident(reg_num) ##1 rd_en && is_ident(reg_num)
        |=> rd_data[ARCH_LSB +: 8] == ARCH_V5TE && rd_data[IMPL_LSB +: 8] == IMPL)
        else $error("write reached the identification word");

    ////////////////////////////////////////////////////////////////
    // checks on the control store and its unimplemented attribute bit
    chk_attr_low: assert property (@(posedge clk) disable iff (!rstn)
        !attr_enable && !control[ATTR_BIT])
        else $error("attribute select set");

    chk_ctrl_bit_clear: assert property (@(posedge clk) disable iff (!rstn)
        wr_en && is_control(reg_num) && wr_data[ATTR_BIT] |=> !control[ATTR_BIT])
        else $error("attribute bit stored a one");

    chk_ctrl_write: assert property (@(posedge clk) disable iff (!rstn)
        wr_en && is_control(reg_num)
        |=> control[31:2] == $past(wr_data[31:2]) && control[0] == $past(wr_data[0]))
        else $error("control write not stored");

    chk_ctrl_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(wr_en && is_control(reg_num))
        |=> control == $past(control))
        else $error("control changed without a write");

    cov_ident_read: cover property (@(posedge clk) disable iff (!rstn) rd_en && reg_num == REG_IDENT);
    cov_ident_write: cover property (@(posedge clk) disable iff (!rstn) wr_en && reg_num == REG_IDENT);
    cov_attr_write: cover property (@(posedge clk) disable iff (!rstn) wr_en && reg_num == REG_CONTROL && wr_data[1]);
    cov_back_to_back: cover property (@(posedge clk) disable iff (!rstn)
        rd_en && is_ident(reg_num) ##1 rd_en && is_ident(reg_num));
    cov_read_while_write: cover property (@(posedge clk) disable iff (!rstn)
        rd_en && wr_en && is_control(reg_num));
endmodule

// [tb/test_processor_id_register.sv]
// self-checking testbench for the identification register block
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("unexpected %0t %h %h", $time, a, b); end end
module test_processor_id_register
    import ident_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // stepping and core revision differ so the two fields can be told apart
    localparam logic [31:0] ID = {IMPL_DEFAULT, 8'h05, GEN_DEFAULT, 3'h5, PROD_DEFAULT, 4'h2};
    logic        clk     = 1'b0;
    logic        rstn    = 1'b0;
    logic        rd_en   = 1'b0;
    logic        wr_en   = 1'b0;
    logic [3:0]  reg_num = 4'h0;
    logic [31:0] wr_data = 32'h0000_0000;
    logic [31:0] rd_data;
    logic        rd_valid;
    logic        attr_enable;
    int          err_count = 0;
    int          n_tests   = 0;
    processor_id_register #(.CREV(3'h5), .STEP(4'h2)) uut (.clk(clk), .rstn(rstn), .rd_en(rd_en),
        .wr_en(wr_en), .reg_num(reg_num), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .attr_enable(attr_enable));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic rd(input logic [3:0] r, input logic [31:0] e);
        @(posedge clk);
        #1 rd_en = 1'b1;
        reg_num = r;
        @(posedge clk);
        #1 rd_en = 1'b0;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, e)
    endtask
    task automatic wr(input logic [3:0] r, input logic [31:0] d);
        @(posedge clk);
        #1 wr_en = 1'b1;
        reg_num = r;
        wr_data = d;
        @(posedge clk);
        #1 wr_en = 1'b0;
    endtask
    task automatic test_ident();
        rd(4'h0, ID);
        `CHK(rd_data[31:24], IMPL_DEFAULT)
        `CHK(rd_data[9:4], PROD_DEFAULT)
        `CHK(rd_data[23:16], 8'h05)
        `CHK(rd_data[3:0], 4'h2)
        `CHK(rd_data[12:10], 3'h5)
        `CHK(rd_data[15:13], GEN_DEFAULT)
        $display("test_ident done");
    endtask
    task automatic test_ident_write();
        wr(4'h0, 32'hFFFF_FFFF);
        rd(4'h0, ID);
        wr(4'h0, 32'h0000_0000);
        rd(4'h0, ID);
        $display("test_ident_write done");
    endtask
    task automatic test_control();
        wr(REG_CONTROL, 32'hA5A5_FFFF);
        rd(REG_CONTROL, 32'hA5A5_FFFD);
        `CHK(attr_enable, 1'b0)
        @(posedge clk);
        #1 `CHK(rd_valid, 1'b0)
        `CHK(rd_data, 32'h0000_0000)
        wr(REG_CONTROL, 32'h0000_0002);
        rd(REG_CONTROL, 32'h0000_0000);
        wr(REG_CONTROL, 32'h0000_C3C1);
        rd(REG_CONTROL, 32'h0000_C3C1);
        `CHK(attr_enable, 1'b0)
        $display("test_control done");
    endtask
    task automatic test_unmapped();
        wr(4'hF, 32'h1234_5678);
        rd(4'hF, 32'h0000_0000);
        rd(4'h0, ID);
        $display("test_unmapped done");
    endtask
    // requests on consecutive edges, a read beside a write, and a write to the fixed word
    task automatic test_back_to_back();
        @(posedge clk);
        #1 wr_en = 1'b1;
        reg_num = REG_CONTROL;
        wr_data = 32'h0000_5A50;
        @(posedge clk);
        #1 wr_data = 32'h0000_0F0C;
        rd_en = 1'b1;
        @(posedge clk);
        #1 `CHK(rd_valid, 1'b1)
        `CHK(rd_data, 32'h0000_5A50)
        wr_en = 1'b0;
        @(posedge clk);
        #1 `CHK(rd_data, 32'h0000_0F0C)
        wr_en = 1'b1;
        rd_en = 1'b0;
        reg_num = REG_IDENT;
        wr_data = 32'hFFFF_FFFF;
        @(posedge clk);
        #1 `CHK(rd_valid, 1'b0)
        `CHK(rd_data, 32'h0000_0000)
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(posedge clk);
        #1 `CHK(rd_data, ID)
        @(posedge clk);
        #1 `CHK(rd_data, ID)
        `CHK(attr_enable, 1'b0)
        rd_en = 1'b0;
        $display("test_back_to_back done");
    endtask
    // reset in mid-run while a read answer stands
    task automatic test_reset();
        wr(REG_CONTROL, 32'h0000_F0F0);
        rd(REG_CONTROL, 32'h0000_F0F0);
        rstn = 1'b0;
        #1 `CHK(rd_valid, 1'b0)
        `CHK(rd_data, 32'h0000_0000)
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        rd(REG_CONTROL, CONTROL_RESET);
        rd(REG_IDENT, ID);
        $display("test_reset done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        #1 rstn = 1'b1;
        test_ident();
        test_ident_write();
        test_control();
        test_unmapped();
        test_back_to_back();
        test_reset();
        test_done();
    end
    initial begin
        #4000;
        err_count++;
        test_done();
    end
endmodule
